// ### design/fps_defs.vh
// Operation
// - only keep or add protection, never remove
// - disallowed scenario write leaves register unchanged
// - from 0-4 allowed targets per table
// - from 5-7 allowed targets per table
// - protection register reads active scenario
// - status at index 0x5, normal-mode access
// - special modes: fail rw, done read-only
// - buffer empty flag set, write-one clears
// - zero to buffer flag mid-sequence aborts, errors
// - interrupt requests from flags and enables
// - all-done clear while buffer flag clear
// - no all-done when pending command fetched
// - protection violation flag, w1c, blocks launch
// - access error flag, w1c, blocks launch
// - blank set by good verify, cleared on launch
// - fail set by failed verify, w1c
// - done low while an operation is active
// - only four command codes, others error
// - no launch before clock divider written
`ifndef FPS_DEFS_VH
`define FPS_DEFS_VH
// register indices; byte address is four times the index
`define FPS_IDX_DIV      6'h00
`define FPS_IDX_CFG      6'h03
`define FPS_IDX_PROT     6'h04
`define FPS_IDX_STAT     6'h05
`define FPS_IDX_CMD      6'h06
`define FPS_IDX_ARRAY    6'h08
// status bit positions
`define FPS_B_BEMPTY     7
`define FPS_B_ALLDONE    6
`define FPS_B_PROTECT_VIOLATION_FLAG      5
`define FPS_B_ACCESS_ERROR_FLAG     4
`define FPS_B_BLANK      2
`define FPS_B_FAIL       1
`define FPS_B_DONE       0
// config bit positions
`define FPS_B_BE_IE      7
`define FPS_B_CC_IE      6
// command codes
`define FPS_CMD_VERIFY   8'h05
`define FPS_CMD_PROG     8'h20
`define FPS_CMD_SECTOR   8'h40
`define FPS_CMD_MASS     8'h41
// reset values and sequence states
`define FPS_PROT_RST     3'h7
`define FPS_OP_CYCLES    8'h40
`define FPS_SEQ_IDLE     2'h0
`define FPS_SEQ_ADDR     2'h1
`define FPS_SEQ_CMD      2'h2
`define FPS_HTRANS_NSEQ  2'h2
`endif

// ### design/fps_flash_status.v
`timescale 1ns/1ps
`include "fps_defs.vh"

module fps_flash_status (
	input  wire        ref_clk,          // bus clock
	input  wire        nrst,             // async reset, active low
	input  wire        hsel,             // slave select
	input  wire [7:0]  haddr,            // byte address
	input  wire [1:0]  htrans,           // transfer type
	input  wire        hwrite,           // write when high
	input  wire [2:0]  hsize,            // transfer size
	input  wire [31:0] hwdata,           // write data
	input  wire        hready,           // bus ready
	output reg  [31:0] hrdata,           // read data
	output reg         hreadyout,        // slave ready
	output reg         hresp,            // always okay
	input  wire        special_mode,     // special mode level
	input  wire        prot_hit,         // chk_addr lies in a protected area
	input  wire        array_erased,     // verify result for active command
	input  wire        stop_req,         // stop instruction pulse
	output reg  [15:0] chk_addr,         // address being launched
	output reg         irq_buf_empty,    // buffer empty request
	output reg         irq_complete      // command complete request
);

	// ----------------------------------------------------------------
	// sequence states
	// ----------------------------------------------------------------
	localparam [1:0] SEQ_IDLE = `FPS_SEQ_IDLE;
	localparam [1:0] SEQ_ADDR = `FPS_SEQ_ADDR;
	localparam [1:0] SEQ_CMD  = `FPS_SEQ_CMD;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	reg  [2:0]  prot_ff;
	reg  [6:0]  div_ff;
	reg         div_ld_ff;
	reg         be_ie_ff;
	reg         cc_ie_ff;
	reg  [1:0]  seq_ff;
	reg  [7:0]  cmd_ff;
	reg         bempty_ff;
	reg         alldone_ff;
	reg         protect_violation_flag_ff;
	reg         access_error_flag_ff;
	reg         blank_ff;
	reg         fail_ff;
	reg         pend_ff;
	reg  [7:0]  pend_cmd_ff;
	reg         act_ff;
	reg  [7:0]  act_cmd_ff;
	reg  [7:0]  tmr_ff;
	reg         wr_ff;
	reg  [5:0]  widx_ff;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	wire        take;
	wire [5:0]  aidx;
	wire [7:0]  wb;
	wire        wr_stat;
	wire        wr_cmd;
	wire        wr_arr;
	wire        wr_prot;
	wire        wr_other;
	reg  [7:0]  allow;
	reg  [7:0]  stat_rd;
	reg  [7:0]  rd_byte;

	assign take     = hsel & hready & (htrans == `FPS_HTRANS_NSEQ);
	assign aidx     = haddr[7:2];
	assign wb       = hwdata[7:0];
	assign wr_stat  = wr_ff & (widx_ff == `FPS_IDX_STAT);
	assign wr_cmd   = wr_ff & (widx_ff == `FPS_IDX_CMD);
	assign wr_arr   = wr_ff & (widx_ff == `FPS_IDX_ARRAY);
	assign wr_prot  = wr_ff & (widx_ff == `FPS_IDX_PROT);
	assign wr_other = wr_ff & ~wr_stat & ~wr_cmd & ~wr_arr;

	// allowed target scenarios, one bit per target
	always @* begin
		case (prot_ff)
			3'h0:    allow = 8'h0f;
			3'h1:    allow = 8'h0a;
			3'h2:    allow = 8'h0c;
			3'h3:    allow = 8'h08;
			3'h4:    allow = 8'h18;
			3'h5:    allow = 8'h3c;
			3'h6:    allow = 8'h5a;
			default: allow = 8'hff;
		endcase
	end

	always @* begin
		stat_rd = 8'h00;
		// fail and done read zero outside special modes
		stat_rd[`FPS_B_BEMPTY]  = bempty_ff;
		stat_rd[`FPS_B_ALLDONE] = alldone_ff;
		stat_rd[`FPS_B_PROTECT_VIOLATION_FLAG]   = protect_violation_flag_ff;
		stat_rd[`FPS_B_ACCESS_ERROR_FLAG]  = access_error_flag_ff;
		stat_rd[`FPS_B_BLANK]   = blank_ff;
		stat_rd[`FPS_B_FAIL]    = special_mode & fail_ff;
		stat_rd[`FPS_B_DONE]    = special_mode & ~act_ff;
	end

	always @* begin
		case (aidx)
			`FPS_IDX_DIV:  rd_byte = {div_ld_ff, div_ff};
			`FPS_IDX_CFG:  rd_byte = {be_ie_ff, cc_ie_ff, 6'h00};
			`FPS_IDX_PROT: rd_byte = {5'h00, prot_ff};
			`FPS_IDX_STAT: rd_byte = stat_rd;
			`FPS_IDX_CMD:  rd_byte = cmd_ff;
			default:       rd_byte = 8'h00;
		endcase
	end

	// ----------------------------------------------------------------
	// command sequence and launch
	// ----------------------------------------------------------------
	wire        be_w1;
	wire        seq_busy;
	wire        abort_seq;
	wire        launch_try;
	wire        launch_ok;
	wire        blocked;
	wire        cmd_ok;
	wire        is_pe;
	wire        launch;
	wire        seq_err;
	wire        pv_set;
	wire        fetch;
	wire        op_end;
	wire        verify_end;
	wire        ab_zero;
	wire        ab_other;
	wire        ab_arr_again;
	wire        ab_arr_odd;
	wire        ab_cmd_order;
	wire        ab_early;
	wire        er_code;
	wire        er_div;
	wire        er_stop;
	wire        clr_protect_violation_flag;
	wire        clr_access_error_flag;
	wire        clr_fail;

	assign be_w1      = wr_stat & wb[`FPS_B_BEMPTY];
	assign seq_busy   = (seq_ff != SEQ_IDLE);
	assign launch_try = be_w1 & (seq_ff == SEQ_CMD);
	// a set error flag holds off every launch
	assign blocked    = protect_violation_flag_ff | access_error_flag_ff | (special_mode & fail_ff);
	assign cmd_ok     = (cmd_ff == `FPS_CMD_VERIFY) | (cmd_ff == `FPS_CMD_PROG) |
	                    (cmd_ff == `FPS_CMD_SECTOR) | (cmd_ff == `FPS_CMD_MASS);
	assign is_pe      = (cmd_ff != `FPS_CMD_VERIFY);
	assign launch_ok  = launch_try & ~blocked & cmd_ok & div_ld_ff;
	assign pv_set     = launch_ok & is_pe & prot_hit;
	assign launch     = launch_ok & ~pv_set;

	// sequence violations; any one of them mid-sequence drops the half-built command
	assign ab_zero      = wr_stat & ~wb[`FPS_B_BEMPTY] & seq_busy;
	assign ab_other     = wr_other & seq_busy;
	assign ab_arr_again = wr_arr & seq_busy;
	assign ab_arr_odd   = wr_arr & ~seq_busy & hwdata[0];
	assign ab_cmd_order = wr_cmd & (seq_ff != SEQ_ADDR);
	assign ab_early     = be_w1 & (seq_ff == SEQ_ADDR);
	assign abort_seq    = ab_zero | ab_other | ab_arr_again |
	                      ab_arr_odd | ab_cmd_order | ab_early;

	// launch-time refusals and a stop during an active operation; a blocked launch adds nothing to a flag already set
	assign er_code    = launch_try & ~blocked & ~cmd_ok;
	assign er_div     = launch_try & ~blocked & cmd_ok & ~div_ld_ff;
	assign er_stop    = stop_req & act_ff;
	assign seq_err    = abort_seq | er_code | er_div | er_stop;

	// write-one-to-clear strobes; fail only clears in special modes
	assign clr_protect_violation_flag  = wr_stat & wb[`FPS_B_PROTECT_VIOLATION_FLAG];
	assign clr_access_error_flag = wr_stat & wb[`FPS_B_ACCESS_ERROR_FLAG];
	assign clr_fail   = wr_stat & special_mode & wb[`FPS_B_FAIL];

	assign op_end     = act_ff & (tmr_ff == 8'h00);
	// a fetch in the ending cycle keeps the engine busy with no idle gap
	assign fetch      = pend_ff & (~act_ff | op_end);
	assign verify_end = op_end & (act_cmd_ff == `FPS_CMD_VERIFY);

	// ----------------------------------------------------------------
	// bus registers
	// ----------------------------------------------------------------
	// zero wait states: read data is latched at the address edge and stands
	// through the data phase; the index is kept so a write lands with its data
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			wr_ff     <= 1'b0;
			widx_ff   <= 6'h00;
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			wr_ff     <= take & hwrite;
			widx_ff   <= aidx;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (take & ~hwrite) begin
				hrdata <= {24'h00_0000, rd_byte};
			end
		end
	end

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	// a refused scenario write is dropped silently, no flag reports it
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			prot_ff   <= `FPS_PROT_RST;
			div_ff    <= 7'h00;
			div_ld_ff <= 1'b0;
			be_ie_ff  <= 1'b0;
			cc_ie_ff  <= 1'b0;
		end else begin
			if (wr_prot & allow[wb[2:0]]) begin
				prot_ff <= wb[2:0];
			end
			if (wr_ff & (widx_ff == `FPS_IDX_DIV)) begin
				div_ff    <= wb[6:0];
				div_ld_ff <= 1'b1;
			end
			if (wr_ff & (widx_ff == `FPS_IDX_CFG)) begin
				be_ie_ff <= wb[`FPS_B_BE_IE];
				cc_ie_ff <= wb[`FPS_B_CC_IE];
			end
		end
	end

	// ----------------------------------------------------------------
	// sequence tracking
	// ----------------------------------------------------------------
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			seq_ff   <= SEQ_IDLE;
			cmd_ff   <= 8'h00;
			chk_addr <= 16'h0000;
		end else begin
			case (seq_ff)
				SEQ_IDLE: begin
					if (wr_arr & ~hwdata[0]) begin
						chk_addr <= hwdata[15:0];
						seq_ff   <= SEQ_ADDR;
					end
				end
				SEQ_ADDR: begin
					if (abort_seq) begin
						seq_ff <= SEQ_IDLE;
					end else if (wr_cmd) begin
						cmd_ff <= wb;
						seq_ff <= SEQ_CMD;
					end
				end
				SEQ_CMD: begin
					if (abort_seq | be_w1) begin
						seq_ff <= SEQ_IDLE;
					end
				end
				default: seq_ff <= SEQ_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// two-stage command pipeline
	// ----------------------------------------------------------------
	// a launch while the buffer is full replaces the waiting command
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pend_ff     <= 1'b0;
			pend_cmd_ff <= 8'h00;
			act_ff      <= 1'b0;
			act_cmd_ff  <= 8'h00;
			tmr_ff      <= 8'h00;
		end else begin
			if (launch) begin
				pend_ff     <= 1'b1;
				pend_cmd_ff <= cmd_ff;
			end else if (fetch) begin
				pend_ff <= 1'b0;
			end
			if (fetch) begin
				act_ff     <= 1'b1;
				act_cmd_ff <= pend_cmd_ff;
				tmr_ff     <= `FPS_OP_CYCLES;
			end else if (op_end) begin
				act_ff <= 1'b0;
			end else if (act_ff) begin
				tmr_ff <= tmr_ff - 8'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// status flags; a hardware set wins over a same-cycle clear, except buffer empty, where a launch wins over a fetch
	// ----------------------------------------------------------------
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			bempty_ff  <= 1'b1;
			alldone_ff <= 1'b1;
			protect_violation_flag_ff   <= 1'b0;
			access_error_flag_ff  <= 1'b0;
			blank_ff   <= 1'b0;
			fail_ff    <= 1'b0;
		end else begin
			// buffer frees when the pending entry moves to active
			if (launch) begin
				bempty_ff <= 1'b0;
			end else if (fetch) begin
				bempty_ff <= 1'b1;
			end
			// stays low across an end that overlaps a fetch
			alldone_ff <= bempty_ff & ~launch & ~act_ff & ~pend_ff & ~fetch;
			protect_violation_flag_ff   <= pv_set | (protect_violation_flag_ff & ~clr_protect_violation_flag);
			access_error_flag_ff  <= seq_err | (access_error_flag_ff & ~clr_access_error_flag);
			if (verify_end & array_erased) begin
				blank_ff <= 1'b1;
			end else if (launch) begin
				blank_ff <= 1'b0;
			end
			fail_ff <= (verify_end & ~array_erased & special_mode) | (fail_ff & ~clr_fail);
		end
	end

	// ----------------------------------------------------------------
	// interrupt requests
	// ----------------------------------------------------------------
	// levels, not pulses: a request stands until its flag or enable clears
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			irq_buf_empty <= 1'b0;
			irq_complete  <= 1'b0;
		end else begin
			irq_buf_empty <= bempty_ff & be_ie_ff;
			irq_complete  <= alldone_ff & cc_ie_ff;
		end
	end

endmodule

// ### test/fps_flash_status_asserts.sv
`timescale 1ns/1ps
module fps_flash_status_asserts (
	input wire        ref_clk,       // clock
	input wire        nrst,          // reset
	input wire        hsel,          // select
	input wire [7:0]  haddr,         // address
	input wire [1:0]  htrans,        // transfer
	input wire        hwrite,        // write
	input wire [31:0] hwdata,        // write data
	input wire        hready,        // ready
	input wire [31:0] hrdata,        // read data
	input wire        hreadyout,     // slave ready
	input wire        hresp,         // response
	input wire        special_mode,  // mode
	input wire [15:0] chk_addr,      // launch address
	input wire        irq_buf_empty, // request
	input wire        irq_complete   // request
);
	wire tk = hsel & hready & (htrans == 2'h2);
	reg  rs_ff, rp_ff, wa_ff, wc_ff;
	// ----
	// data phase markers, one cycle after the address phase
	// ----
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rs_ff <= 1'b0;
			rp_ff <= 1'b0;
			wa_ff <= 1'b0;
			wc_ff <= 1'b0;
		end else begin
			rs_ff <= tk & !hwrite & (haddr == 8'h14);
			rp_ff <= tk & !hwrite & (haddr == 8'h10);
			wa_ff <= tk & hwrite & (haddr == 8'h20);
			wc_ff <= tk & hwrite & (haddr == 8'h0c);
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	sequence cfg_off;
		wc_ff && (hwdata[7:6] == 2'b00);
	endsequence
	AST_OKAY: assert property (hreadyout && !hresp) else $error("bus not okay");
	AST_STAT_RSVD: assert property (rs_ff |-> hrdata[31:8] == 24'h0 && !hrdata[3])
		else $error("reserved status bits set");
	AST_NORM_FD: assert property (rs_ff && !special_mode |-> hrdata[1:0] == 2'b00)
		else $error("fail or done seen in normal mode");
	AST_DONE_BE: assert property (rs_ff && hrdata[6] |-> hrdata[7])
		else $error("all done without buffer empty");
	AST_SPEC_DONE: assert property (rs_ff && special_mode && hrdata[6] |-> hrdata[0])
		else $error("done low while idle");
	AST_PROT_W: assert property (rp_ff |-> hrdata[31:3] == 29'h0)
		else $error("protection read too wide");
	AST_ADDR: assert property ($changed(chk_addr) |-> $past(wa_ff))
		else $error("launch address changed without array write");
	AST_IRQ_OFF: assert property (cfg_off |-> ##2 (!irq_buf_empty && !irq_complete))
		else $error("request with enables cleared");
endmodule
bind fps_flash_status fps_flash_status_asserts u_chk (.ref_clk(ref_clk), .nrst(nrst),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
	.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.special_mode(special_mode), .chk_addr(chk_addr), .irq_buf_empty(irq_buf_empty),
	.irq_complete(irq_complete));

// ### test/fps_flash_status_tb.sv
`timescale 1ns/1ps
module fps_flash_status_tb;
	localparam [63:0] OK_TBL = 64'hff5a3c18080c0a0f;
	localparam [31:0] ALL = 32'hffffffff;
	reg         ref_clk = 1'b0;
	reg         nrst = 1'b0;
	reg         hsel = 1'b0;
	reg  [7:0]  haddr = 8'h00;
	reg  [1:0]  htrans = 2'h0;
	reg         hwrite = 1'b0;
	reg  [31:0] hwdata = 32'h0;
	reg         special_mode = 1'b0;
	reg         stop_req = 1'b0;
	reg         verify_ok = 1'b0;
	reg  [31:0] rv;
	wire [31:0] hrdata;
	wire [15:0] chk_addr;
	wire        hreadyout, hresp, prot_hit, array_erased, irq_buf_empty, irq_complete;
	integer     bad_count = 0;
	integer     cmp_count = 0;
	integer     f, t;
	always #2.5 ref_clk = ~ref_clk;
	fps_flash_status dut (.ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .special_mode(special_mode),
		.prot_hit(prot_hit), .array_erased(array_erased), .stop_req(stop_req),
		.chk_addr(chk_addr), .irq_buf_empty(irq_buf_empty), .irq_complete(irq_complete));
	fps_flash_stub far (.chk_addr(chk_addr), .prot_lo(16'h8000), .verify_ok(verify_ok),
		.prot_hit(prot_hit), .array_erased(array_erased));
	// ----
	// bus tasks
	// ----
	task chk(input string n, input [31:0] e, input [31:0] g);
		begin
			cmp_count = cmp_count + 1;
			if (g !== e) begin
				bad_count = bad_count + 1;
				$display("mismatch %0s expected %h seen %h", n, e, g);
			end
		end
	endtask
	task bus(input w, input [7:0] a, input [31:0] d);
		begin
			hsel <= 1'b1;
			haddr <= a;
			hwrite <= w;
			htrans <= 2'h2;
			@(posedge ref_clk);
			while (hreadyout !== 1'b1) @(posedge ref_clk);
			htrans <= 2'h0;
			hwdata <= d;
			@(posedge ref_clk);
			while (hreadyout !== 1'b1) @(posedge ref_clk);
			rv = hrdata;
		end
	endtask
	task rdc(input string n, input [7:0] a, input [31:0] m, input [31:0] e);
		begin
			bus(1'b0, a, 32'h0);
			chk(n, e, rv & m);
		end
	endtask
	task cmd(input [15:0] a, input [7:0] c);
		begin
			bus(1'b1, 8'h20, {16'h0, a});
			bus(1'b1, 8'h18, {24'h0, c});
			bus(1'b1, 8'h14, 32'h80);
		end
	endtask
	task rst;
		begin
			nrst <= 1'b0;
			repeat (2) @(posedge ref_clk);
			nrst <= 1'b1;
			@(posedge ref_clk);
		end
	endtask
	task results;
		begin
			$display("compares %0d mismatches %0d", cmp_count, bad_count);
			if (bad_count == 0 && cmp_count > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask
	// ----
	// tests
	// ----
	initial begin
		rst;
		rdc("stat", 8'h14, ALL, 32'hc0);
		rdc("prot", 8'h10, ALL, 32'h7);
		$display("reset test done");
		for (f = 0; f < 8; f = f + 1) begin
			for (t = 0; t < 8; t = t + 1) begin
				rst;
				bus(1'b1, 8'h10, f);
				bus(1'b1, 8'h10, t);
				rdc("prot", 8'h10, ALL, OK_TBL[f*8+t] ? t : f);
			end
		end
		$display("protection test done");
		cmd(16'h1000, 8'h20);
		rdc("stat", 8'h14, ALL, 32'hd0);
		bus(1'b1, 8'h14, 32'h10);
		rdc("stat", 8'h14, ALL, 32'hc0);
		bus(1'b1, 8'h00, 32'h04);
		cmd(16'h1000, 8'h21);
		rdc("stat", 8'h14, ALL, 32'hd0);
		bus(1'b1, 8'h14, 32'h10);
		cmd(16'h1000, 8'h20);
		rdc("stat", 8'h14, 32'h43, 32'h0);
		repeat (80) @(posedge ref_clk);
		rdc("stat", 8'h14, ALL, 32'hc0);
		cmd(16'h9000, 8'h40);
		rdc("stat", 8'h14, ALL, 32'he0);
		chk("chk_addr", 32'h9000, {16'h0, chk_addr});
		bus(1'b1, 8'h14, 32'h00);
		rdc("stat", 8'h14, ALL, 32'he0);
		bus(1'b1, 8'h14, 32'h20);
		rdc("stat", 8'h14, ALL, 32'hc0);
		bus(1'b1, 8'h20, 32'h1000);
		bus(1'b1, 8'h14, 32'h00);
		rdc("stat", 8'h14, ALL, 32'hd0);
		bus(1'b1, 8'h14, 32'h10);
		cmd(16'h1000, 8'h40);
		repeat (3) @(posedge ref_clk);
		stop_req <= 1'b1;
		@(posedge ref_clk);
		stop_req <= 1'b0;
		repeat (80) @(posedge ref_clk);
		rdc("stat", 8'h14, 32'h10, 32'h10);
		bus(1'b1, 8'h14, 32'h10);
		bus(1'b1, 8'h18, 32'h20);
		rdc("stat", 8'h14, ALL, 32'hd0);
		bus(1'b1, 8'h14, 32'h10);
		cmd(16'h1000, 8'h20);
		cmd(16'h1002, 8'h20);
		rdc("stat", 8'h14, 32'hc0, 32'h0);
		repeat (60) @(posedge ref_clk);
		rdc("stat", 8'h14, 32'hc0, 32'h80);
		repeat (80) @(posedge ref_clk);
		rdc("stat", 8'h14, ALL, 32'hc0);
		$display("normal mode test done");
		special_mode <= 1'b1;
		cmd(16'h1000, 8'h05);
		@(posedge ref_clk);
		rdc("stat", 8'h14, 32'h41, 32'h0);
		repeat (80) @(posedge ref_clk);
		rdc("stat", 8'h14, ALL, 32'hc3);
		bus(1'b1, 8'h14, 32'h02);
		rdc("stat", 8'h14, ALL, 32'hc1);
		verify_ok <= 1'b1;
		cmd(16'h1000, 8'h05);
		repeat (80) @(posedge ref_clk);
		rdc("stat", 8'h14, ALL, 32'hc5);
		cmd(16'h1000, 8'h41);
		repeat (80) @(posedge ref_clk);
		rdc("stat", 8'h14, ALL, 32'hc1);
		$display("special mode test done");
		bus(1'b1, 8'h0c, 32'hc0);
		repeat (3) @(posedge ref_clk);
		chk("irq_be", 32'h1, {31'h0, irq_buf_empty});
		chk("irq_cc", 32'h1, {31'h0, irq_complete});
		bus(1'b1, 8'h0c, 32'h00);
		repeat (3) @(posedge ref_clk);
		chk("irq_be", 32'h0, {31'h0, irq_buf_empty});
		chk("irq_cc", 32'h0, {31'h0, irq_complete});
		rdc("unmapped", 8'h3c, ALL, 32'h0);
		$display("interrupt test done");
		results;
	end
	// a hang would leave the verdict unprinted
	initial begin
		#200000;
		bad_count = bad_count + 1;
		$display("timeout");
		results;
	end
endmodule

// ### test/fps_flash_stub.sv
`timescale 1ns/1ps
// ----
// outside protection logic and array
// ----
module fps_flash_stub (
	input  wire [15:0] chk_addr,    // address under launch
	input  wire [15:0] prot_lo,     // first protected address
	input  wire        verify_ok,   // verify outcome chosen by bench
	output wire        prot_hit,    // address is protected
	output wire        array_erased // verify result
);
	assign prot_hit = (chk_addr >= prot_lo);
	assign array_erased = verify_ok;
endmodule
